// >>> src/cntn_top.sv
// Downstream port containment: capability registers, trigger logic,
// cause and source capture, MSI and correctable-message requests.
// Assumes error inputs are one-cycle pulses synchronous to clk and
// an Avalon-MM master that holds each request until waitrequest is low.
//
// Contract
// - The low sixteen header bits read the fixed containment code and ignore writes.
// - The header version field always reads one.
// - The header next pointer reads zero, ending the capability chain.
// - A read-only five-bit field reports MSI vector one for the interrupt.
// - Trigger select zero disables; one arms on uncorrectable error or fatal message; three reserved; resets to zero.
// - Trigger select two also fires on a received non-fatal message.
// - The completion select bit picks Completer Abort when clear and Unsupported Request when set, reset clear.
// - With interrupt enable set a trigger raises an MSI request, otherwise none; irq follows unmasked fired, ERR_COR and release flags either way; reset clear.
// - With correctable-message enable set a trigger sends an ERR_COR message; reset clear.
// - The fired bit sets on a trigger and clears only by writing one.
// - A two-bit write-one-to-clear cause field records uncorrectable, non-fatal or fatal.
// - The interrupt pending bit sets only when firing with interrupt enable set, cleared by writing one.
// - The source field captures the requester of the fatal or non-fatal message that fires containment, reset zero.
// - The structure sits at offset 250h where the previous capability points.
`timescale 1ns/10ps
module cntn_top (
	input  logic                      clk,
	input  logic                      nrst,
	input  logic                      ce,
	input  logic                      errUncorr,
	input  logic                      msgFatal,
	input  logic                      msgNonFatal,
	input  logic [15:0]               msgRequesterId,
	input  logic [cntn_pkg::ADDR_W-1:0] avsAddress,
	input  logic                      avsRead,
	input  logic                      avsWrite,
	input  logic [cntn_pkg::DATA_W-1:0] avsWriteData,
	input  logic [3:0]                avsByteEnable,
	output logic [cntn_pkg::DATA_W-1:0] avsReadData,
	output logic                      avsWaitRequest,
	output logic                      contained,
	output logic [2:0]                cplStatus,
	output logic                      msiReq,
	output logic [4:0]                msiVector,
	output logic                      errCorReq,
	output logic                      irq
);
	import cntn_pkg::*;

	// Control and status state
	cntn_trig_t    trigSel_reg;
	logic          cplUr_reg;
	logic          irqEn_reg;
	logic          corEn_reg;
	logic          fired_reg;
	cntn_cause_t   cause_reg;
	logic          irqPend_reg;
	logic [15:0]   srcId_reg;

	// Bus slave state
	cntn_slv_t     slvState_reg;
	cntn_slv_t     slvState_next;
	logic          waitReq_reg;
	logic [31:0]   readData_reg;

	// Output registers
	logic          contained_reg;
	logic [2:0]    cplStatus_reg;
	logic          msiReq_reg;
	logic [4:0]    msiVector_reg;
	logic          errCorReq_reg;

	// Event flag block
	logic [EV_W-1:0] evStatus;
	logic [EV_W-1:0] evMask;
	logic [EV_W-1:0] evSet;
	logic [EV_W-1:0] evClr;
	logic            evIrq;

	// Bus decode
	wire reqValid  = avsRead | avsWrite;
	wire accept    = reqValid && (slvState_reg == SL_ANSWER);
	wire wrAccept  = accept && avsWrite;
	wire hitHdr    = (avsAddress == OFS_HEADER);
	wire hitCtrl   = (avsAddress == OFS_CTRL);
	wire hitStat   = (avsAddress == OFS_STAT);
	wire hitEvStat = (avsAddress == OFS_EV_STAT);
	wire hitEvMask = (avsAddress == OFS_EV_MASK);

	// Header and capability bytes are read-only, so only byte two
	// of the control word is writable
	wire wrCtrl    = wrAccept && hitCtrl && avsByteEnable[2];
	wire wrStat    = wrAccept && hitStat && avsByteEnable[0];
	wire wrEvStat  = wrAccept && hitEvStat && avsByteEnable[0];
	wire wrEvMask  = wrAccept && hitEvMask && avsByteEnable[0];

	// Write-one-to-clear masks for the status word
	wire [7:0] stClr     = wrStat ? avsWriteData[7:0] : 8'h00;
	wire       clrFired  = stClr[STS_FIRED];
	wire [1:0] clrCause  = stClr[STS_CAUSE +: 2];
	wire       clrIrqP   = stClr[STS_IRQ];

	// New control field values
	wire [1:0] selWr     = avsWriteData[CTL_SEL_LSB +: 2];
	wire       cplWr     = avsWriteData[CTL_CPL_BIT];
	wire       irqEnWr   = avsWriteData[CTL_IRQ_BIT];
	wire       corEnWr   = avsWriteData[CTL_COR_BIT];

	// Trigger qualification; reserved select value acts as disabled
	wire trigOn  = (trigSel_reg == TRIG_FATAL) ||
	               (trigSel_reg == TRIG_NONFATAL);
	wire nfArm   = (trigSel_reg == TRIG_NONFATAL) && msgNonFatal;
	wire trigHit = trigOn && (errUncorr || msgFatal || nfArm);

	// A second event while contained is dropped so the first cause
	// and source stay visible to software
	wire fire    = trigHit && !fired_reg;

	// Fatal outranks non-fatal outranks internal error
	wire [1:0] causeNew = msgFatal ? CAUSE_FATAL :
	                      nfArm    ? CAUSE_NONFATAL :
	                                 CAUSE_UNCORR;
	wire fromMsg = msgFatal || nfArm;

	// Status next values, set winning over clear
	wire [7:0] firedW1c = cntn_w1c(8'(fired_reg), 8'(clrFired), 8'(fire));
	wire [7:0] irqPW1c  = cntn_w1c(8'(irqPend_reg), 8'(clrIrqP),
	                               8'(fire && irqEn_reg));
	wire       fired_next   = firedW1c[0];
	wire       irqPend_next = irqPW1c[0];
	wire [1:0] cause_next   = fire ? causeNew :
	                          (cause_reg & ~clrCause);
	wire [15:0] srcId_next  = (fire && fromMsg) ? msgRequesterId :
	                          srcId_reg;

	// Control next values
	wire [1:0] trigSel_next = wrCtrl ? selWr   : trigSel_reg;
	wire       cplUr_next   = wrCtrl ? cplWr   : cplUr_reg;
	wire       irqEn_next   = wrCtrl ? irqEnWr : irqEn_reg;
	wire       corEn_next   = wrCtrl ? corEnWr : corEn_reg;

	// Selected completion status follows the control bit at once
	wire [2:0] cpl_next = cplUr_next ? CPL_UR : CPL_CA;

	// Event flags for the local interrupt
	wire relEv = clrFired && fired_reg && !fire;
	assign evSet[EV_FIRED]   = fire;
	assign evSet[EV_COR]     = fire && corEn_reg;
	assign evSet[EV_RELEASE] = relEv;
	assign evClr = wrEvStat ? avsWriteData[EV_W-1:0] : '0;

	// Read words
	wire [31:0] hdrWord  = {CAP_NEXT, CAP_VER, CAP_ID};
	wire [31:0] ctrlWord = {11'h000, corEn_reg, irqEn_reg, cplUr_reg,
	                        trigSel_reg, 11'h000,
	                        msiVector_reg};
	wire [31:0] statWord = {srcId_reg, 12'h000, irqPend_reg,
	                        cause_reg, fired_reg};
	wire [31:0] evStWord = {{(32-EV_W){1'b0}}, evStatus};
	wire [31:0] evMkWord = {{(32-EV_W){1'b0}}, evMask};

	// Unmapped addresses read zero and drop writes
	wire [31:0] readSel = hitHdr    ? hdrWord  :
	                      hitCtrl   ? ctrlWord :
	                      hitStat   ? statWord :
	                      hitEvStat ? evStWord :
	                      hitEvMask ? evMkWord :
	                                  32'h0000_0000;

	// Slave answers one cycle after seeing a request
	always_comb begin
		slvState_next = slvState_reg;
		unique case (slvState_reg)
			SL_IDLE: begin
				if (reqValid) begin
					slvState_next = SL_ANSWER;
				end
			end
			SL_ANSWER: begin
				slvState_next = SL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			slvState_reg <= SL_IDLE;
			waitReq_reg  <= 1'b1;
			readData_reg <= RDATA_RST;
		end else if (ce) begin
			slvState_reg <= slvState_next;
			waitReq_reg  <= (slvState_next != SL_ANSWER);
			if (slvState_next == SL_ANSWER) begin
				readData_reg <= avsRead ? readSel : RDATA_RST;
			end
		end
	end

	// Control register
	always_ff @(posedge clk) begin
		if (!nrst) begin
			trigSel_reg <= TRIG_OFF;
			cplUr_reg   <= 1'b0;
			irqEn_reg   <= 1'b0;
			corEn_reg   <= 1'b0;
		end else if (ce) begin
			trigSel_reg <= cntn_trig_t'(trigSel_next);
			cplUr_reg   <= cplUr_next;
			irqEn_reg   <= irqEn_next;
			corEn_reg   <= corEn_next;
		end
	end

	// Status and source capture
	always_ff @(posedge clk) begin
		if (!nrst) begin
			fired_reg   <= 1'b0;
			cause_reg   <= CAUSE_UNCORR;
			irqPend_reg <= 1'b0;
			srcId_reg   <= SRC_RST;
		end else if (ce) begin
			fired_reg   <= fired_next;
			cause_reg   <= cntn_cause_t'(cause_next);
			irqPend_reg <= irqPend_next;
			srcId_reg   <= srcId_next;
		end
	end

	// Port-side outputs
	always_ff @(posedge clk) begin
		if (!nrst) begin
			contained_reg <= 1'b0;
			cplStatus_reg <= CPL_CA;
			msiReq_reg    <= 1'b0;
			msiVector_reg <= MSI_VEC_RST;
			errCorReq_reg <= 1'b0;
		end else if (ce) begin
			contained_reg <= fired_next;
			cplStatus_reg <= cpl_next;
			msiReq_reg    <= fire && irqEn_reg;
			errCorReq_reg <= fire && corEn_reg;
		end
	end

	cntn_event_flags #(
		.W        (EV_W)
	) u_events (
		.clk      (clk),
		.nrst     (nrst),
		.ce       (ce),
		.setVec   (evSet),
		.clrVec   (evClr),
		.maskWrEn (wrEvMask),
		.maskData (avsWriteData[EV_W-1:0]),
		.status   (evStatus),
		.mask     (evMask),
		.irq      (evIrq)
	);

	assign avsReadData    = readData_reg;
	assign avsWaitRequest = waitReq_reg;
	assign contained      = contained_reg;
	assign cplStatus      = cplStatus_reg;
	assign msiReq         = msiReq_reg;
	assign msiVector      = msiVector_reg;
	assign errCorReq      = errCorReq_reg;
	assign irq            = evIrq;

endmodule

// >>> pkg/cntn_pkg.sv
// Constants, encodings and helpers for the containment block.
// Assumes a 32-bit register bus with byte addresses.
package cntn_pkg;

	localparam int          ADDR_W       = 12;
	localparam int          DATA_W       = 32;

	// Register byte offsets
	localparam logic [11:0] OFS_HEADER   = 12'h250;
	localparam logic [11:0] OFS_CTRL     = 12'h254;
	localparam logic [11:0] OFS_STAT     = 12'h258;
	localparam logic [11:0] OFS_EV_STAT  = 12'h270;
	localparam logic [11:0] OFS_EV_MASK  = 12'h274;

	// Capability header contents and MSI vector reset value
	localparam logic [15:0] CAP_ID       = 16'h001D;
	localparam logic [3:0]  CAP_VER      = 4'h1;
	localparam logic [11:0] CAP_NEXT     = 12'h000;
	localparam logic [4:0]  MSI_VEC_RST  = 5'h01;

	// Control field positions
	localparam int          CTL_SEL_LSB  = 16;
	localparam int          CTL_CPL_BIT  = 18;
	localparam int          CTL_IRQ_BIT  = 19;
	localparam int          CTL_COR_BIT  = 20;

	// Status field positions
	localparam int          STS_FIRED    = 0;
	localparam int          STS_CAUSE    = 1;
	localparam int          STS_IRQ      = 3;
	localparam int          SRC_LSB      = 16;

	// Completion status codes
	localparam logic [2:0]  CPL_CA       = 3'h4;
	localparam logic [2:0]  CPL_UR       = 3'h1;

	// Event flag layout
	localparam int          EV_W         = 3;
	localparam int          EV_FIRED     = 0;
	localparam int          EV_COR       = 1;
	localparam int          EV_RELEASE   = 2;

	// Reset values
	localparam logic [15:0] SRC_RST      = 16'h0000;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

	typedef enum logic [1:0] {
		TRIG_OFF      = 2'h0,
		TRIG_FATAL    = 2'h1,
		TRIG_NONFATAL = 2'h2,
		TRIG_RSVD     = 2'h3
	} cntn_trig_t;

	typedef enum logic [1:0] {
		CAUSE_UNCORR   = 2'h0,
		CAUSE_NONFATAL = 2'h1,
		CAUSE_FATAL    = 2'h2,
		CAUSE_RSVD     = 2'h3
	} cntn_cause_t;

	typedef enum logic {
		SL_IDLE,
		SL_ANSWER
	} cntn_slv_t;

	// Write-one-to-clear with set winning over clear
	function automatic logic [7:0] cntn_w1c(
		input logic [7:0] cur,
		input logic [7:0] clr,
		input logic [7:0] set
	);
		cntn_w1c = (cur & ~clr) | set;
	endfunction

endpackage

// >>> src/cntn_event_flags.sv
// Sticky event flags with mask and one level interrupt.
// Assumes set and clear vectors are single-cycle pulses from the owner.
`timescale 1ns/10ps
module cntn_event_flags #(
	parameter int W = 3
) (
	input  logic         clk,
	input  logic         nrst,
	input  logic         ce,
	input  logic [W-1:0] setVec,
	input  logic [W-1:0] clrVec,
	input  logic         maskWrEn,
	input  logic [W-1:0] maskData,
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic         irq
);
	import cntn_pkg::*;

	logic [W-1:0] status_reg;
	logic [W-1:0] status_next;
	logic [W-1:0] mask_reg;
	logic [W-1:0] mask_next;
	logic         irq_reg;
	logic [7:0]   w1cOut;

	// Set wins, so an event in the clearing cycle survives
	assign w1cOut      = cntn_w1c(8'(status_reg), 8'(clrVec), 8'(setVec));
	assign status_next = w1cOut[W-1:0];
	assign mask_next   = maskWrEn ? maskData : mask_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			status_reg <= '0;
			mask_reg   <= '0;
			irq_reg    <= 1'b0;
		end else if (ce) begin
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_reg    <= |(status_next & mask_next);
		end
	end

	assign status = status_reg;
	assign mask   = mask_reg;
	assign irq    = irq_reg;

endmodule

// >>> testbench/cntn_top_checker.sv
// Port checker for the containment block.
// Assumes one clock, ce held high and a master that holds requests.
`timescale 1ns/10ps
module cntn_top_checker (
	input logic                        clk,
	input logic                        nrst,
	input logic                        errUncorr,
	input logic                        msgFatal,
	input logic                        msgNonFatal,
	input logic [cntn_pkg::ADDR_W-1:0] avsAddress,
	input logic                        avsRead,
	input logic                        avsWrite,
	input logic [cntn_pkg::DATA_W-1:0] avsReadData,
	input logic                        avsWaitRequest,
	input logic                        contained,
	input logic [2:0]                  cplStatus,
	input logic                        msiReq,
	input logic [4:0]                  msiVector,
	input logic                        errCorReq
);
	import cntn_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	wire anyEv = errUncorr | msgFatal | msgNonFatal;
	sequence reqTaken;
		(avsRead || avsWrite) && avsWaitRequest;
	endsequence
	sequence answerOnce;
		!avsWaitRequest ##1 avsWaitRequest;
	endsequence
	bus_one_wait_a: assert property (
		reqTaken |=> answerOnce) else $error("bus answer late");
	header_const_a: assert property (
		avsRead && !avsWaitRequest && avsAddress == OFS_HEADER
		|-> avsReadData == {CAP_NEXT, CAP_VER, CAP_ID})
		else $error("header value wrong");
	vector_fixed_a: assert property (
		msiVector == MSI_VEC_RST) else $error("vector wrong");
	cpl_code_a: assert property (
		cplStatus == CPL_CA || cplStatus == CPL_UR)
		else $error("completion code wrong");
	msi_on_fire_a: assert property (
		msiReq |-> $rose(contained) && $past(anyEv))
		else $error("msi without trigger");
	msi_pulse_a: assert property (
		msiReq |=> !msiReq) else $error("msi not a pulse");
	cor_on_fire_a: assert property (
		errCorReq |-> $rose(contained)) else $error("cor without trigger");
	fire_cause_a: assert property (
		$rose(contained) |-> $past(anyEv)) else $error("fired without event");
	release_write_a: assert property (
		$fell(contained) |-> $past(avsWrite && !avsWaitRequest
		&& avsAddress == OFS_STAT)) else $error("released without write");
	hold_contained_a: assert property (
		contained && !avsWrite |=> contained) else $error("dropped");
endmodule

bind cntn_top cntn_top_checker cntn_top_checker_i (.clk, .nrst,
	.errUncorr, .msgFatal, .msgNonFatal, .avsAddress, .avsRead,
	.avsWrite, .avsReadData, .avsWaitRequest, .contained, .cplStatus,
	.msiReq, .msiVector, .errCorReq);

// >>> testbench/cntn_link_partner.sv
// Device below the port: sends error messages on command.
// Assumes go is a one-cycle strobe from the bench.
`timescale 1ns/10ps
module cntn_link_partner (
	input  logic        clk,
	input  logic        go,
	input  logic [1:0]  kind,
	input  logic [15:0] id,
	output logic        errUncorr,
	output logic        msgFatal,
	output logic        msgNonFatal,
	output logic [15:0] msgRequesterId
);
	always @(posedge clk) begin
		errUncorr   <= go && kind == 2'h0;
		msgNonFatal <= go && kind == 2'h1;
		msgFatal    <= go && kind == 2'h2;
		// Id is junk outside a message, so stale values cannot pass
		msgRequesterId <= go ? id : ~msgRequesterId;
	end
endmodule

// >>> testbench/tb_downstream_port_containment.sv
// Self-checking bench for the containment block.
// Assumes the package, design and partner model compile first.
`timescale 1ns/10ps
module tb_downstream_port_containment;
	import cntn_pkg::*;
	typedef struct packed {
		logic [1:0] sel;
		logic [1:0] kind;
		logic       fires;
	} cntn_row_t;
	logic        clk, nrst, go, errUncorr, msgFatal, msgNonFatal;
	logic        avsRead, avsWrite, avsWaitRequest, contained, irq;
	logic        msiReq, errCorReq, msiSeen, corSeen;
	logic [1:0]  kind;
	logic [15:0] id, msgRequesterId;
	logic [11:0] avsAddress;
	logic [31:0] avsWriteData, avsReadData, rd;
	logic [2:0]  cplStatus;
	logic [4:0]  msiVector;
	logic        ce;
	logic [3:0]  be;
	int          err_count, num_checks;
	cntn_row_t   r;
	// Kind uses the cause encoding
	cntn_row_t   rows [8] = '{'{2'h1, 2'h0, 1'b1}, '{2'h1, 2'h2, 1'b1},
		'{2'h1, 2'h1, 1'b0}, '{2'h2, 2'h1, 1'b1}, '{2'h2, 2'h2, 1'b1},
		'{2'h0, 2'h2, 1'b0}, '{2'h3, 2'h2, 1'b0}, '{2'h2, 2'h0, 1'b1}};

	cntn_top cntn_top_i (.clk, .nrst, .ce, .errUncorr, .msgFatal,
		.msgNonFatal, .msgRequesterId, .avsAddress, .avsRead, .avsWrite,
		.avsWriteData, .avsByteEnable(be), .avsReadData,
		.avsWaitRequest, .contained, .cplStatus, .msiReq, .msiVector,
		.errCorReq, .irq);
	cntn_link_partner cntn_link_partner_i (.clk, .go, .kind, .id,
		.errUncorr, .msgFatal, .msgNonFatal, .msgRequesterId);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Called just after a rising edge; one idle edge after release
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		avsAddress   <= a;
		avsWriteData <= d;
		avsRead      <= !wr;
		avsWrite     <= wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avsWaitRequest && n < 20);
		if (avsWaitRequest) begin
			err_count++;
			summarize();
		end
		rd = avsReadData;
		avsRead  <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge clk);
	endtask

	task automatic send(input logic [1:0] k, input logic [15:0] i);
		go   <= 1'b1;
		kind <= k;
		id   <= i;
		@(posedge clk);
		go <= 1'b0;
		repeat (2) @(posedge clk);
		msiSeen = msiReq;
		corSeen = errCorReq;
		@(posedge clk);
	endtask

	initial begin
		{nrst, go, avsRead, avsWrite, kind, id} = '0;
		{avsAddress, avsWriteData, err_count, num_checks} = '0;
		{ce, be} = 5'h1F;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			bus(1'b1, OFS_CTRL, {11'h0, i[1], i[0], i[2], r.sel, 16'h0});
			send(r.kind, 16'h0A50 ^ 16'(i));
			chk("contained", contained, r.fires);
			chk("msi", msiSeen, r.fires & i[0]);
			chk("errcor", corSeen, r.fires & i[1]);
			chk("cpl", cplStatus, i[2] ? CPL_UR : CPL_CA);
			bus(1'b0, OFS_STAT, 32'h0);
			chk("status", rd[3:0], {r.fires & i[0],
				r.fires ? r.kind : 2'h0, r.fires});
			if (r.fires && r.kind != 2'h0)
				chk("source", rd[31:16], 16'h0A50 ^ 16'(i));
			bus(1'b1, OFS_STAT, 32'h0000_000F);
			chk("released", contained, 1'b0);
		end
		// Loop left fired, ERR_COR and release events behind
		bus(1'b0, OFS_EV_STAT, 32'h0000_0000);
		chk("events", rd, 32'h0000_0007);
		bus(1'b1, OFS_EV_STAT, 32'h0000_0007);
		bus(1'b1, OFS_CTRL, 32'h0002_0000);
		bus(1'b1, OFS_EV_MASK, 32'h0000_0001);
		chk("irq idle", irq, 1'b0);
		send(2'h2, 16'hBEEF);
		chk("irq", irq, 1'b1);
		// Zero write and a late event must leave the record alone
		bus(1'b1, OFS_STAT, 32'h0000_0000);
		send(2'h1, 16'h1111);
		bus(1'b0, OFS_STAT, 32'h0000_0000);
		chk("hold", rd, 32'hBEEF_0005);
		bus(1'b1, OFS_EV_MASK, 32'h0000_0000);
		@(posedge clk);
		chk("masked", irq, 1'b0);
		bus(1'b1, OFS_EV_MASK, 32'h0000_0001);
		@(posedge clk);
		chk("unmasked", irq, 1'b1);
		bus(1'b1, OFS_EV_STAT, 32'h0000_0001);
		@(posedge clk);
		chk("irq clear", irq, 1'b0);
		bus(1'b1, OFS_HEADER, 32'hFFFF_FFFF);
		bus(1'b0, OFS_HEADER, 32'h0000_0000);
		chk("header", rd, 32'h0001_001D);
		bus(1'b0, 12'h300, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		bus(1'b1, OFS_STAT, 32'h0000_0001);
		chk("released2", contained, 1'b0);
		// Enable low must swallow an event that would fire
		ce <= 1'b0;
		send(2'h2, 16'h2222);
		ce <= 1'b1;
		@(posedge clk);
		chk("frozen", contained, 1'b0);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		chk("rst contained", contained, 1'b0);
		bus(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("rst ctrl", rd, 32'h0000_0001);
		bus(1'b0, OFS_STAT, 32'h0000_0000);
		chk("rst status", rd, 32'h0000_0000);
		// Control fields live in lane two only
		be <= 4'h3;
		bus(1'b1, OFS_CTRL, 32'h001F_0000);
		be <= 4'hF;
		bus(1'b0, OFS_CTRL, 32'h0000_0000);
		chk("lane gate", rd, 32'h0000_0001);
		summarize();
	end
endmodule
